// ==== pkg/parallel_port_params.svh ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: offsets, field codes and reset values of the parallel port block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes:   byte offsets, only the low eight address bits are decoded
//////////////////////////////////////////////////////////////////////////////
`ifndef PARALLEL_PORT_PARAMS_SVH
`define PARALLEL_PORT_PARAMS_SVH

// register byte offsets, buffer base as the high offset nibble
`define REG_MODE 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_CONFIG 8'h0c
`define REG_STATUS 8'h10
`define REG_MASK 8'h14
`define REG_BUF_BASE 4'h2

// reset values and mode write mask
`define MODE_RESET 16'h0000
`define ADDR_RESET 16'h0000
`define WRITABLE_MASK 16'h7fff

// interrupt select codes
`define IRQ_NONE 2'h0
`define IRQ_EACH 2'h1
`define IRQ_FOURTH 2'h2

// address step codes
`define STEP_NONE 2'h0
`define STEP_UP 2'h1
`define STEP_DOWN 2'h2
`define STEP_BUF 2'h3

// port mode codes
`define PORT_LEGACY 2'h0
`define PORT_ENHANCED 2'h1
`define PORT_MASTER2 2'h2
`define PORT_MASTER1 2'h3

// status and mask bit positions, last buffer index
`define EVT_PORT 0
`define EVT_DONE 1
`define BUF_LAST 2'h3

`endif

// ==== pkg/parallel_port_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: types shared by the parallel port block
// Assumes: constants come from the params header
// Notes:   mode_type matches the mode register bit layout 15..0
//////////////////////////////////////////////////////////////////////////////
package parallel_port_pkg;

    typedef struct packed {
        logic busy;
        logic [1:0] irqSelect;
        logic [1:0] addrStepSelect;
        logic wideTransfer;
        logic [1:0] portMode;
        logic [1:0] setupWait;
        logic [3:0] strobeWait;
        logic [1:0] endWait;
    } mode_type;

    typedef enum logic [1:0] {MS_IDLE, MS_SETUP, MS_STROBE, MS_HOLD} master_state_type;

    typedef struct packed {
        logic rd;
        logic [7:0] rdAddr;
        logic wr;
        logic [7:0] wrAddr;
        logic [31:0] wdata;
    } bus_access_type;

endpackage

// ==== rtl/ahb_reg_port.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: AHB-Lite slave front end, turns transfers into register strobes
// Assumes: single word transfers, clock enable stalls the bus via hreadyout
// Notes:   reads decode in the address phase, writes in the data phase
//////////////////////////////////////////////////////////////////////////////
module ahb_reg_port
    import parallel_port_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register side
    output bus_access_type access,
    input wire logic [31:0] readData
);

    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] hrdata_q;

    // hsize is not decoded: only whole-word transfers are supported
    wire take = ce && hsel && hready && htrans[1];
    wire readTake = take && !hwrite;

    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign access.rd = readTake;
    assign access.rdAddr = haddr[7:0];
    assign access.wr = wrPend_q && ce;
    assign access.wrAddr = wrAddr_q;
    assign access.wdata = hwdata;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else if (ce) begin
            wrPend_q <= take && hwrite;
            if (take) wrAddr_q <= haddr[7:0];
            if (readTake) hrdata_q <= readData;
        end
    end

endmodule

// ==== rtl/slave_buffer.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: slave mode buffers between software and the external host
// Assumes: host pins already qualified by the slave mode of the port
// Notes:   out buffers are written by software, in buffers by the host
//////////////////////////////////////////////////////////////////////////////
module slave_buffer #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 8
) (
    // system
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // software side
    input wire logic swWrite,
    input wire logic [$clog2(DEPTH)-1:0] swWrIndex,
    input wire logic [WIDTH-1:0] swData,
    input wire logic [$clog2(DEPTH)-1:0] swRdIndex,
    output logic [WIDTH-1:0] swReadData,
    // host side
    input wire logic addressable,
    input wire logic autoStep,
    input wire logic [$clog2(DEPTH)-1:0] hostAddr,
    input wire logic hostCapture,
    input wire logic hostStep,
    input wire logic [WIDTH-1:0] hostData,
    output logic [WIDTH-1:0] hostReadData,
    output logic [$clog2(DEPTH)-1:0] hostIndex
);

    localparam int IW = $clog2(DEPTH);

    logic [WIDTH-1:0] outBuf_q [DEPTH];
    logic [WIDTH-1:0] inBuf_q [DEPTH];
    logic [IW-1:0] ptr_q;

    // enhanced slave takes the host's address, legacy with buffer stepping uses the pointer, otherwise index 0
    assign hostIndex = addressable ? hostAddr : (autoStep ? ptr_q : '0);
    assign swReadData = inBuf_q[swRdIndex];
    assign hostReadData = outBuf_q[hostIndex];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ptr_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                outBuf_q[i] <= '0;
                inBuf_q[i] <= '0;
            end
        end else if (ce) begin
            if (swWrite) outBuf_q[swWrIndex] <= swData;
            if (hostCapture) inBuf_q[hostIndex] <= hostData;
            if (!autoStep) ptr_q <= '0;
            else if (hostStep) ptr_q <= IW'(ptr_q + 1'b1);
        end
    end

endmodule

// ==== rtl/parallel_port_mode_control.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: parallel port with two master and two slave modes
// Assumes: clock is the peripheral clock, pins synchronous to it
// Notes:   registers on AHB-Lite, level interrupt from status and mask
//////////////////////////////////////////////////////////////////////////////
`include "parallel_port_params.svh"

module parallel_port_mode_control
    import parallel_port_pkg::*;
#(
    parameter int BUF_DEPTH = 4
) (
    // system
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // interrupt
    output logic irq,
    // master strobes and address
    output logic [15:0] portAddressLines,
    output logic [1:0] chipSelectOut,
    output logic readStrobe,
    output logic writeStrobe,
    output logic enableStrobe,
    output logic strobeOe,
    // data pins
    input wire logic [15:0] portDataIn,
    output logic [15:0] portDataOut,
    output logic [15:0] portDataOe,
    // host strobes in slave modes
    input wire logic hostSelect,
    input wire logic hostRead,
    input wire logic hostWrite,
    input wire logic [1:0] hostAddr
);

    bus_access_type acc;
    logic [31:0] readData;
    mode_type mode_q;
    master_state_type state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic finish;
    logic isWrite_q;
    logic [15:0] addr_q, readWord_q, dataOut_q;
    logic [1:0] csConfig_q, status_q, mask_q;
    logic prevWr_q, prevRd_q;
    logic [7:0] swReadData, hostReadData;
    logic [1:0] hostIndex;

    ahb_reg_port u_bus (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .access(acc),
        .readData(readData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [3:0] phaseCycles(input mode_type m, input master_state_type ph,
                                               input logic wr);
        logic [3:0] n;
        n = 4'h0;
        case (ph)
            MS_SETUP: n = (m.strobeWait == 4'h0) ? 4'h1 : {2'h0, m.setupWait} + 4'h1;
            MS_STROBE: n = (m.strobeWait == 4'h0) ? 4'h1 : m.strobeWait;
            MS_HOLD: n = (m.strobeWait == 4'h0) ? {3'h0, wr} : {2'h0, m.endWait};
            default: n = 4'h0;
        endcase
        return n;
    endfunction

    function automatic logic [15:0] nextAddress(input logic [15:0] a, input logic [1:0] step,
                                                input logic [1:0] cs);
        logic [15:0] keep, moved;
        keep = {cs, 14'h0000};
        moved = a;
        case (step)
            `STEP_UP: moved = a + 16'h0001;
            `STEP_DOWN: moved = a - 16'h0001;
            default: moved = a;
        endcase
        return (moved & ~keep) | (a & keep);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // decode

    wire masterMode = mode_q.portMode[1];
    wire master1 = mode_q.portMode == `PORT_MASTER1;
    wire master2 = mode_q.portMode == `PORT_MASTER2;
    wire slaveMode = !masterMode;
    wire idle = state_q == MS_IDLE;
    wire busyFlag = !idle;
    wire inSetup = state_q == MS_SETUP;
    wire inStrobe = state_q == MS_STROBE;
    wire inHold = state_q == MS_HOLD;

    wire wrMode = acc.wr && acc.wrAddr == `REG_MODE;
    wire wrAddr = acc.wr && acc.wrAddr == `REG_ADDR;
    wire wrData = acc.wr && acc.wrAddr == `REG_DATA;
    wire wrConfig = acc.wr && acc.wrAddr == `REG_CONFIG;
    wire wrStatus = acc.wr && acc.wrAddr == `REG_STATUS;
    wire wrMask = acc.wr && acc.wrAddr == `REG_MASK;
    wire wrBuf = acc.wr && acc.wrAddr[7:4] == `REG_BUF_BASE;
    wire rdData = acc.rd && acc.rdAddr == `REG_DATA;

    // in master mode one data access starts exactly one bus cycle, ignored while busy
    wire launchRead = rdData && masterMode && idle;
    wire launchWrite = wrData && masterMode && idle;
    wire launch = launchRead || launchWrite;
    wire [15:0] writeWord = mode_q.wideTransfer ? acc.wdata[15:0] : {8'h00, acc.wdata[7:0]};
    wire [15:0] readWord = mode_q.wideTransfer ? portDataIn : {8'h00, portDataIn[7:0]};
    wire strobeEnd = inStrobe && cnt_q == 4'h1;
    wire [3:0] holdLen = phaseCycles(mode_q, MS_HOLD, isWrite_q);

    ////////////////////////////////////////////////////////////////////////////
    // master cycle sequencer

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        finish = 1'b0;
        case (state_q)
            MS_IDLE: begin
                if (launch) begin
                    state_d = MS_SETUP;
                    cnt_d = phaseCycles(mode_q, MS_SETUP, launchWrite);
                end
            end
            MS_SETUP: begin
                if (cnt_q == 4'h1) begin
                    state_d = MS_STROBE;
                    cnt_d = phaseCycles(mode_q, MS_STROBE, isWrite_q);
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            MS_STROBE: begin
                if (cnt_q != 4'h1) begin
                    cnt_d = cnt_q - 4'h1;
                end else if (holdLen == 4'h0) begin
                    state_d = MS_IDLE;
                    finish = 1'b1;
                end else begin
                    state_d = MS_HOLD;
                    cnt_d = holdLen;
                end
            end
            MS_HOLD: begin
                if (cnt_q == 4'h1) begin
                    state_d = MS_IDLE;
                    finish = 1'b1;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: state_d = MS_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= MS_IDLE;
            cnt_q <= 4'h0;
            isWrite_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (launch) isWrite_q <= launchWrite;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // slave host strobes

    wire hostWrActive = slaveMode && hostSelect && hostWrite;
    wire hostRdActive = slaveMode && hostSelect && hostRead;
    wire hostWrStart = hostWrActive && !prevWr_q;
    wire hostEnd = (!hostWrActive && prevWr_q) || (!hostRdActive && prevRd_q);
    wire addressable = mode_q.portMode == `PORT_ENHANCED;
    wire autoStep = mode_q.portMode == `PORT_LEGACY && mode_q.addrStepSelect == `STEP_BUF;

    slave_buffer #(
        .DEPTH(BUF_DEPTH),
        .WIDTH(8)
    ) u_buf (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .swWrite(wrBuf),
        .swWrIndex(acc.wrAddr[3:2]),
        .swData(acc.wdata[7:0]),
        .swRdIndex(acc.rdAddr[3:2]),
        .swReadData(swReadData),
        .addressable(addressable),
        .autoStep(autoStep),
        .hostAddr(hostAddr),
        .hostCapture(hostWrStart),
        .hostStep(hostEnd),
        .hostData(portDataIn[7:0]),
        .hostReadData(hostReadData),
        .hostIndex(hostIndex)
    );

    ////////////////////////////////////////////////////////////////////////////
    // events and interrupt

    wire eachEvent = mode_q.irqSelect == `IRQ_EACH && (finish || hostEnd);
    wire fourthEvent = mode_q.irqSelect == `IRQ_FOURTH && hostEnd && hostIndex == `BUF_LAST;
    wire [1:0] eventSet = {finish, eachEvent || fourthEvent};
    wire [1:0] eventClr = wrStatus ? acc.wdata[1:0] : 2'h0;
    // a new event beats a simultaneous write-one clear
    wire [1:0] status_d = (status_q & ~eventClr) | eventSet;

    assign irq = |(status_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= mode_type'(`MODE_RESET);
            addr_q <= `ADDR_RESET;
            csConfig_q <= 2'h0;
            status_q <= 2'h0;
            mask_q <= 2'h0;
        end else if (ce) begin
            // mode and address are frozen while a cycle runs
            if (wrMode && idle) mode_q <= mode_type'(acc.wdata[15:0] & `WRITABLE_MASK);
            if (wrAddr && idle) addr_q <= acc.wdata[15:0];
            else if (finish) addr_q <= nextAddress(addr_q, mode_q.addrStepSelect, csConfig_q);
            if (wrConfig) csConfig_q <= acc.wdata[1:0];
            if (wrMask) mask_q <= acc.wdata[1:0];
            status_q <= status_d;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readWord_q <= 16'h0000;
            dataOut_q <= 16'h0000;
            prevWr_q <= 1'b0;
            prevRd_q <= 1'b0;
        end else if (ce) begin
            if (strobeEnd && !isWrite_q) readWord_q <= readWord;
            if (launchWrite) dataOut_q <= writeWord;
            else if (slaveMode) dataOut_q <= {8'h00, hostReadData};
            prevWr_q <= hostWrActive;
            prevRd_q <= hostRdActive;
        end
    end

    wire [15:0] modeView = {busyFlag, mode_q[14:0]};
    assign readData = (acc.rdAddr == `REG_MODE) ? {16'h0000, modeView} :
                      (acc.rdAddr == `REG_ADDR) ? {16'h0000, addr_q} :
                      (acc.rdAddr == `REG_DATA) ? {16'h0000, readWord_q} :
                      (acc.rdAddr == `REG_CONFIG) ? {30'h0, csConfig_q} :
                      (acc.rdAddr == `REG_STATUS) ? {30'h0, status_q} :
                      (acc.rdAddr == `REG_MASK) ? {30'h0, mask_q} :
                      (acc.rdAddr[7:4] == `REG_BUF_BASE) ? {24'h0, swReadData} : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // pins

    wire masterDrive = masterMode && busyFlag && isWrite_q;
    wire slaveDrive = hostRdActive;

    assign readStrobe = master1 ? (busyFlag && !isWrite_q) : (master2 && inStrobe && !isWrite_q);
    assign writeStrobe = master2 && inStrobe && isWrite_q;
    assign enableStrobe = master1 && inStrobe;
    assign strobeOe = masterMode;
    assign portAddressLines = masterMode ? addr_q : 16'h0000;
    assign chipSelectOut = (masterMode && busyFlag) ? (csConfig_q & addr_q[15:14]) : 2'h0;
    assign portDataOut = dataOut_q;
    // upper byte lanes stay released unless wide master
    assign portDataOe = {{8{masterDrive && mode_q.wideTransfer}}, {8{masterDrive || slaveDrive}}};

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !ce);

    launch_sets_busy_a: assert property (launch |=> busyFlag)
        else $error("busy not set after launch");
    finish_clears_busy_a: assert property (finish |=> !busyFlag && modeView[15] == 1'b0)
        else $error("busy still set after cycle end");
    strobe_width_a: assert property ($rose(inStrobe) && mode_q.strobeWait == 4'h3 |->
        inStrobe[*3] ##1 !inStrobe)
        else $error("strobe width not three periods");
    fast_write_a: assert property (launchWrite && mode_q.strobeWait == 4'h0 |=>
        inSetup ##1 inStrobe ##1 inHold ##1 !busyFlag)
        else $error("forced write timing wrong");
    fast_read_a: assert property (launchRead && mode_q.strobeWait == 4'h0 |=>
        inSetup ##1 inStrobe ##1 !busyFlag)
        else $error("forced read timing wrong");
    setup_length_a: assert property (launch && mode_q.strobeWait != 4'h0 && mode_q.setupWait == 2'h3 |=>
        inSetup[*4] ##1 inStrobe)
        else $error("setup wait not four periods");
    address_up_a: assert property (finish && mode_q.addrStepSelect == `STEP_UP && csConfig_q == 2'h0 |=>
        addr_q == 16'($past(addr_q) + 16'h0001))
        else $error("address did not increment");
    address_down_a: assert property (finish && mode_q.addrStepSelect == `STEP_DOWN && csConfig_q == 2'h0 |=>
        addr_q == 16'($past(addr_q) - 16'h0001))
        else $error("address did not decrement");
    select_bits_kept_a: assert property (finish && csConfig_q == 2'h3 |=>
        addr_q[15:14] == $past(addr_q[15:14]))
        else $error("chip-select address bits stepped");
    narrow_upper_a: assert property (!mode_q.wideTransfer || slaveMode |-> portDataOe[15:8] == 8'h00)
        else $error("upper byte driven when not wide master");
    each_event_a: assert property (finish && mode_q.irqSelect == `IRQ_EACH |=> status_q[`EVT_PORT])
        else $error("cycle end did not raise event");
    fourth_event_a: assert property (hostEnd && hostIndex == `BUF_LAST && mode_q.irqSelect == `IRQ_FOURTH
        |=> status_q[`EVT_PORT])
        else $error("fourth buffer access did not raise event");

    write_cycle_c: cover property (launchWrite ##[1:40] finish);
    read_cycle_c: cover property (launchRead ##[1:40] finish);
    fourth_access_c: cover property (fourthEvent);

endmodule

// ==== verification/port_peripheral.sv ====
// Purpose: external peripheral on the master side of the parallel port
// Assumes: strobes active high, pins resolved here from both drivers
// Notes: undriven pins show READ_WORD under readStrobe, else the inverse of the last level, not a hold
module port_peripheral #(
    parameter logic [15:0] READ_WORD = 16'hc3a5
) (
    // pins
    input wire logic clock,
    input wire logic readStrobe,
    input wire logic writeStrobe,
    input wire logic enableStrobe,
    input wire logic [15:0] portDataOut,
    input wire logic [15:0] portDataOe,
    output logic [15:0] portDataIn,
    // observation
    output logic [15:0] lastWrite
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] held = 16'h0000;
    logic [15:0] drive;
    assign drive = readStrobe ? READ_WORD : ~held;
    assign portDataIn = (portDataOe & portDataOut) | (~portDataOe & drive);
    initial lastWrite = 16'h0000;
    always @(posedge clock) begin
        held <= portDataIn;
        if (writeStrobe || (enableStrobe && !readStrobe)) begin
            lastWrite <= portDataOut;
        end
    end
endmodule

// ==== verification/parallel_port_mode_control_tb.sv ====
// Purpose: self-checking bench of the parallel port block
// Assumes: ce high except in the stall check, slave host pins idle
// Notes: busy is polled over the bus, never counted in cycles
`include "parallel_port_params.svh"
module parallel_port_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0, irq, rdS, wrS, enS;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp;
    logic [15:0] pAddr, dIn, dOut, dOe, lastWrite;
    int failures = 0, num_checks = 0;
    parallel_port_mode_control dut_u (.clock(clock), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .portAddressLines(pAddr),
        .chipSelectOut(), .readStrobe(rdS), .writeStrobe(wrS), .enableStrobe(enS), .strobeOe(),
        .portDataIn(dIn), .portDataOut(dOut), .portDataOe(dOe), .hostSelect(1'b0), .hostRead(1'b0),
        .hostWrite(1'b0), .hostAddr(2'h0));
    port_peripheral peer_u (.clock(clock), .readStrobe(rdS), .writeStrobe(wrS), .enableStrobe(enS),
        .portDataOut(dOut), .portDataOe(dOe), .portDataIn(dIn), .lastWrite(lastWrite));
    initial forever #2 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata;
    endtask
    // bounded poll, a stuck busy ends as a mismatch
    task wait_idle;
        for (int i = 0; i < 40; i++) begin
            ahb(1'b0, `REG_MODE, 32'h0);
            if (rd[15] === 1'b0) return;
        end
        chk("busy stuck", rd[15], 1'b0);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task test_reset;
        ahb(1'b0, `REG_MODE, 32'h0);
        chk("mode reset", rd, 32'h0);
        chk("irq reset", irq, 1'b0);
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", rd, 32'h0);
        // clock enable low must stall the register bus
        ce <= 1'b0;
        @(posedge clock);
        chk("ready stalled", hreadyout, 1'b0);
        ce <= 1'b1;
        @(posedge clock);
        ahb(1'b0, `REG_MODE, 32'h0);
        chk("mode frozen", rd, 32'h0);
        $display("test reset done");
    endtask
    task test_write_up;
        ahb(1'b1, `REG_MODE, 32'h2a00);
        ahb(1'b1, `REG_ADDR, 32'h0010);
        ahb(1'b1, `REG_DATA, 32'h015a);
        ahb(1'b0, `REG_MODE, 32'h0);
        chk("busy", rd[15], 1'b1);
        chk("narrow oe", dOe, 16'h00ff);
        wait_idle();
        chk("written byte", lastWrite[7:0], 8'h5a);
        chk("upper oe", dOe[15:8], 8'h00);
        ahb(1'b0, `REG_ADDR, 32'h0);
        chk("addr up", rd, 32'h0011);
        ahb(1'b0, `REG_STATUS, 32'h0);
        chk("status", rd[1:0], 2'h3);
        ahb(1'b1, `REG_MASK, 32'h2);
        // mask lands at the task's last edge, let irq settle
        @(posedge clock);
        chk("irq masked on", irq, 1'b1);
        ahb(1'b1, `REG_STATUS, 32'h3);
        ahb(1'b0, `REG_STATUS, 32'h0);
        chk("status cleared", rd[1:0], 2'h0);
        chk("irq off", irq, 1'b0);
        $display("test write up done");
    endtask
    task test_read_down;
        // setup code 11 and strobe 0011 reach the setup and strobe checks
        ahb(1'b1, `REG_MODE, 32'h17cd);
        ahb(1'b0, `REG_MODE, 32'h0);
        chk("mode fields", rd, 32'h17cd);
        ahb(1'b1, `REG_ADDR, 32'h0020);
        ahb(1'b0, `REG_DATA, 32'h0);
        wait_idle();
        ahb(1'b0, `REG_DATA, 32'h0);
        chk("wide read", rd[15:0], 16'hc3a5);
        wait_idle();
        ahb(1'b0, `REG_ADDR, 32'h0);
        chk("addr down", rd, 32'h001e);
        ahb(1'b0, `REG_STATUS, 32'h0);
        chk("no port event", rd[0], 1'b0);
        $display("test read down done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        test_reset();
        test_write_up();
        test_read_down();
        give_verdict();
    end
    initial begin
        #20000;
        failures++;
        give_verdict();
    end
endmodule
